/* rtl/dpram_mailbox_pkg.sv */
// shared constants and bus types for the dual-port ram with mailboxes
// assumes both ports are sampled on one system clock
//
// Functional notes
// - read/write select low writes the array, high reads it, when the port is enabled.
// - reads and writes touch only byte lanes whose select is asserted.
// - global reset is asynchronous and acts on both ports together.
// - global reset clears each burst counter and sets each mask to all ones.
// - global reset drives both mailbox flags and both wrap flags high.
// - top word is the right mailbox, the word below it the left mailbox.
// - a write to the other port's mailbox drives that owner's flag low.
// - a mailbox write sets the flag only with at least one lane selected.
// - owner reading its mailbox raises its flag; needs one lane selected.
// - flag set at the writer's edge and cleared at the reader's edge, no delay.
// - reading the other mailbox never clears; writing your own never sets.
// - on the smallest density mailboxes are the top two of 16-bit space.
// - address width is 18, 17 or 16 bits by density.
// - a read sampled at one edge drives after the next edge, releases after another.
// - combined enable is low-active low and high-active high; taken at the access edge itself, no added latency.
// - output enable high floats the data pins at once, independent of clock.
package dpram_mailbox_pkg;

  localparam int DATA_W       = 36;
  localparam int LANES        = 4;
  localparam int LANE_W       = 9;
  localparam int ADDR_W_LARGE = 18;
  localparam int ADDR_W_MID   = 17;
  localparam int ADDR_W_SMALL = 16;
  localparam int MAX_ADDR_W   = 18;

  localparam logic [MAX_ADDR_W-1:0] COUNTER_RST = 18'h0_0000;
  localparam logic [MAX_ADDR_W-1:0] MASK_RST    = 18'h3_FFFF;
  localparam logic                  FLAG_IDLE   = 1'b1;

  typedef struct packed {
    logic                  chipSelectLowActive;
    logic                  chipSelectHighActive;
    logic                  readWrite;
    logic [LANES-1:0]      byteLaneSelectsN;
    logic                  outputEnableN;
    logic                  addrStrobeN;
    logic                  counterEnableN;
    logic [MAX_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]     dataPinsIn;
  } portBus_t;

endpackage

/* rtl/mailbox_port.sv */
// one port front end: enable decode, lane decode and burst address counter
// assumes bus inputs are synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module mailbox_port #(
  parameter int ADDR_W = dpram_mailbox_pkg::ADDR_W_LARGE
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rstAny,
  input  wire logic                         clkEn,
  input  wire dpram_mailbox_pkg::portBus_t  bus,
  output logic [ADDR_W-1:0]                 accAddr,
  output logic                              wrStrobe,
  output logic                              rdStrobe,
  output logic [dpram_mailbox_pkg::LANES-1:0] laneEn,
  output logic                              wrapFlagN
);
  import dpram_mailbox_pkg::*;

  logic [ADDR_W-1:0] counter_ff;
  logic [ADDR_W-1:0] mask_ff;
  logic [ADDR_W-1:0] mirror_ff;
  logic              wrapFlagN_ff;
  logic [ADDR_W-1:0] nxt_counter;
  logic              nxt_wrapFlagN;

  wire logic              portEnabled = ~bus.chipSelectLowActive & bus.chipSelectHighActive;
  wire logic              loadCounter = ~bus.addrStrobeN & ~bus.counterEnableN;
  wire logic              incCounter  = bus.addrStrobeN & ~bus.counterEnableN;
  wire logic [ADDR_W-1:0] extAddr     = bus.addr[ADDR_W-1:0];
  wire logic              atTop       = (counter_ff & mask_ff) == mask_ff;
  // bits outside the mask are forced to one so the carry skips them
  wire logic [ADDR_W-1:0] stepped     = (((counter_ff | ~mask_ff) + 1'b1) & mask_ff) | (counter_ff & ~mask_ff);
  wire logic [ADDR_W-1:0] incValue    = atTop ? mirror_ff : stepped;

  assign accAddr  = bus.addrStrobeN ? counter_ff : extAddr;
  assign wrStrobe = portEnabled & ~bus.readWrite;
  assign rdStrobe = portEnabled & bus.readWrite;
  assign laneEn   = ~bus.byteLaneSelectsN;
  assign wrapFlagN = wrapFlagN_ff;

  always_comb begin
    nxt_counter   = counter_ff;
    nxt_wrapFlagN = wrapFlagN_ff;
    if (loadCounter) begin
      nxt_counter = extAddr;
    end else if (incCounter) begin
      nxt_counter   = incValue;
      nxt_wrapFlagN = (incValue & mask_ff) != mask_ff;
    end
  end

  always_ff @(posedge clk_sys or posedge rstAny) begin
    if (rstAny) begin
      counter_ff   <= COUNTER_RST[ADDR_W-1:0];
      mask_ff      <= MASK_RST[ADDR_W-1:0];
      mirror_ff    <= COUNTER_RST[ADDR_W-1:0];
      wrapFlagN_ff <= FLAG_IDLE;
    end else if (clkEn) begin
      counter_ff   <= nxt_counter;
      wrapFlagN_ff <= nxt_wrapFlagN;
      if (loadCounter) begin
        mirror_ff <= extAddr;
      end
    end
  end

  default clocking cbPort @(posedge clk_sys); endclocking
  default disable iff (rstAny || !clkEn);

  a_counter_load: assert property (loadCounter |=> counter_ff == $past(extAddr))
    else $error("burst counter did not take the strobed address");
  a_wrap_reload: assert property (incCounter && atTop |=> counter_ff == $past(mirror_ff) && wrapFlagN_ff)
    else $error("wrap did not reload from mirror");
  a_addr_select: assert property (!bus.addrStrobeN |-> accAddr == extAddr)
    else $error("strobed address not used for access");
  a_reset_counter: assert property (disable iff (1'b0) rstAny |-> counter_ff == COUNTER_RST[ADDR_W-1:0]
    && mask_ff == MASK_RST[ADDR_W-1:0] && mirror_ff == COUNTER_RST[ADDR_W-1:0])
    else $error("global reset did not clear the burst counter");

endmodule
`default_nettype wire

/* rtl/dual_port_ram_mailbox.sv */
// dual-port ram with byte lanes, pipelined reads and two mailbox flags
// assumes both port masters are synchronous to clk_sys; data pins resolved outside
`timescale 1ns/1ps
`default_nettype none
module dual_port_ram_mailbox #(
  parameter int ADDR_W = dpram_mailbox_pkg::ADDR_W_LARGE
) (
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  input  wire logic                          clkEn,
  input  wire logic                          globalResetN,
  input  wire dpram_mailbox_pkg::portBus_t   leftBus,
  input  wire dpram_mailbox_pkg::portBus_t   rightBus,
  output logic [dpram_mailbox_pkg::DATA_W-1:0] leftDataPinsOut,
  output logic [dpram_mailbox_pkg::DATA_W-1:0] leftDataPinsOeN,
  output logic [dpram_mailbox_pkg::DATA_W-1:0] rightDataPinsOut,
  output logic [dpram_mailbox_pkg::DATA_W-1:0] rightDataPinsOeN,
  output logic                               leftMailboxFlagN,
  output logic                               rightMailboxFlagN,
  output logic                               leftCounterWrapFlagN,
  output logic                               rightCounterWrapFlagN
);
  import dpram_mailbox_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;
  // top word and the one below it, for any density
  localparam logic [ADDR_W-1:0] RIGHT_MBOX = {ADDR_W{1'b1}};
  localparam logic [ADDR_W-1:0] LEFT_MBOX  = {{(ADDR_W-1){1'b1}}, 1'b0};

  // async reset from either the system or the global pin
  wire logic rstAny = sys_rst | ~globalResetN;

  portBus_t          bus [2];
  logic [ADDR_W-1:0] pAddr [2];
  logic              pWr [2];
  logic              pRd [2];
  logic [LANES-1:0]  pLane [2];
  logic [LANE_W-1:0] laneRd [2][LANES];

  logic [DATA_W-1:0] stageData_ff [2];
  logic [LANES-1:0]  stageLane_ff [2];
  logic [DATA_W-1:0] dout_ff [2];
  logic [LANES-1:0]  laneDrv_ff [2];
  logic [DATA_W-1:0] dataOeN [2];
  logic              leftFlagN_ff;
  logic              rightFlagN_ff;

  assign bus[0] = leftBus;
  assign bus[1] = rightBus;

  mailbox_port #(
    .ADDR_W (ADDR_W)
  ) u_left (
    .clk_sys   (clk_sys),
    .rstAny    (rstAny),
    .clkEn     (clkEn),
    .bus       (leftBus),
    .accAddr   (pAddr[0]),
    .wrStrobe  (pWr[0]),
    .rdStrobe  (pRd[0]),
    .laneEn    (pLane[0]),
    .wrapFlagN (leftCounterWrapFlagN)
  );

  mailbox_port #(
    .ADDR_W (ADDR_W)
  ) u_right (
    .clk_sys   (clk_sys),
    .rstAny    (rstAny),
    .clkEn     (clkEn),
    .bus       (rightBus),
    .accAddr   (pAddr[1]),
    .wrStrobe  (pWr[1]),
    .rdStrobe  (pRd[1]),
    .laneEn    (pLane[1]),
    .wrapFlagN (rightCounterWrapFlagN)
  );

  // lane storage; mailbox words are plain words here
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [LANE_W-1:0] memLane [DEPTH];
    always_ff @(posedge clk_sys) begin
      if (clkEn) begin
        if (pWr[0] && pLane[0][l]) begin
          memLane[pAddr[0]] <= leftBus.dataPinsIn[l*LANE_W +: LANE_W];
        end
        if (pWr[1] && pLane[1][l]) begin
          memLane[pAddr[1]] <= rightBus.dataPinsIn[l*LANE_W +: LANE_W];
        end
      end
    end
    assign laneRd[0][l] = memLane[pAddr[0]];
    assign laneRd[1][l] = memLane[pAddr[1]];
  end

  // two-stage read path and pin enables per port
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [DATA_W-1:0] rdWord;
    logic [LANES-1:0]  rdLanes;
    for (genvar l = 0; l < LANES; l++) begin : g_sel
      assign rdWord[l*LANE_W +: LANE_W] = laneRd[p][l];
      assign dataOeN[p][l*LANE_W +: LANE_W] = {LANE_W{~(laneDrv_ff[p][l] & ~bus[p].outputEnableN)}};
    end
    assign rdLanes = pRd[p] ? pLane[p] : '0;

    always_ff @(posedge clk_sys or posedge rstAny) begin
      if (rstAny) begin
        stageData_ff[p] <= '0;
        stageLane_ff[p] <= '0;
        dout_ff[p]      <= '0;
        laneDrv_ff[p]   <= '0;
      end else if (clkEn) begin
        stageData_ff[p] <= rdWord;
        stageLane_ff[p] <= rdLanes;
        dout_ff[p]      <= stageData_ff[p];
        laneDrv_ff[p]   <= stageLane_ff[p];
      end
    end
  end

  assign leftDataPinsOut  = dout_ff[0];
  assign rightDataPinsOut = dout_ff[1];
  assign leftDataPinsOeN  = dataOeN[0];
  assign rightDataPinsOeN = dataOeN[1];

  // mailbox decode
  wire logic leftAnyLane  = |pLane[0];
  wire logic rightAnyLane = |pLane[1];
  wire logic setRight = pWr[0] && leftAnyLane && (pAddr[0] == RIGHT_MBOX);
  wire logic setLeft  = pWr[1] && rightAnyLane && (pAddr[1] == LEFT_MBOX);
  wire logic clrRight = pRd[1] && rightAnyLane && (pAddr[1] == RIGHT_MBOX);
  wire logic clrLeft  = pRd[0] && leftAnyLane && (pAddr[0] == LEFT_MBOX);

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or posedge rstAny) begin
    if (rstAny) begin
      leftFlagN_ff  <= FLAG_IDLE;
      rightFlagN_ff <= FLAG_IDLE;
    end else if (clkEn) begin
      if (setRight) begin
        rightFlagN_ff <= 1'b0;
      end else if (clrRight) begin
        rightFlagN_ff <= 1'b1;
      end
      if (setLeft) begin
        leftFlagN_ff <= 1'b0;
      end else if (clrLeft) begin
        leftFlagN_ff <= 1'b1;
      end
    end
  end

  assign leftMailboxFlagN  = leftFlagN_ff;
  assign rightMailboxFlagN = rightFlagN_ff;

  // checks
  default clocking cbTop @(posedge clk_sys); endclocking
  default disable iff (rstAny || !clkEn);

  wire logic leftRdTaken = pRd[0] && leftAnyLane;
  wire logic leftWrRight = pWr[0] && leftAnyLane && (pAddr[0] == RIGHT_MBOX);
  wire logic rightOwnWr  = pWr[1] && (pAddr[1] == RIGHT_MBOX);
  wire logic rightRdOwn  = pRd[1] && rightAnyLane && (pAddr[1] == RIGHT_MBOX);
  wire logic rightRdLeft = pRd[1] && (pAddr[1] == LEFT_MBOX);

  sequence sqLeftRead;
    leftRdTaken ##1 1'b1;
  endsequence
  sequence sqLeftDrive;
    (laneDrv_ff[0] != '0) ##1 1'b1;
  endsequence

  a_read_latency: assert property (sqLeftRead |-> ##1 sqLeftDrive)
    else $error("read data not driven on the second edge");
  a_read_release: assert property (!pRd[0] |-> ##2 laneDrv_ff[0] == '0)
    else $error("pins not released two edges after deselect");
  a_lane_gating: assert property (pRd[0] |-> ##2 laneDrv_ff[0] == $past(pLane[0], 2))
    else $error("driven lanes differ from selected lanes");
  a_oe_float: assert property (leftBus.outputEnableN |-> leftDataPinsOeN == '1)
    else $error("data pins driven while output enable is high");
  a_mbox_set: assert property (leftWrRight |=> !rightMailboxFlagN)
    else $error("right flag not set by left mailbox write");
  a_mbox_nolane: assert property (rightMailboxFlagN && !(pWr[0] && leftAnyLane) |=> rightMailboxFlagN)
    else $error("right flag set without a lane-qualified left write");
  a_mbox_clear: assert property (rightRdOwn && !setRight |=> rightMailboxFlagN)
    else $error("right flag not cleared by owner read");
  a_own_noset: assert property (rightOwnWr && rightMailboxFlagN && !setRight |=> rightMailboxFlagN)
    else $error("own mailbox write set own flag");
  a_peer_noclear: assert property (rightRdLeft && !leftMailboxFlagN && !clrLeft |=> !leftMailboxFlagN)
    else $error("peer read cleared the left flag");

  // right port read path, same timing as the left
  wire logic rightRdTaken = pRd[1] && rightAnyLane;

  sequence sqRightRead;
    rightRdTaken ##1 1'b1;
  endsequence
  sequence sqRightDrive;
    (laneDrv_ff[1] != '0) ##1 1'b1;
  endsequence

  a_rread_latency: assert property (sqRightRead |-> ##1 sqRightDrive)
    else $error("right read data not driven on the second edge");
  a_rread_release: assert property (!pRd[1] |-> ##2 laneDrv_ff[1] == '0)
    else $error("right pins not released two edges after deselect");
  a_rlane_gating: assert property (pRd[1] |-> ##2 laneDrv_ff[1] == $past(pLane[1], 2))
    else $error("right driven lanes differ from selected lanes");
  a_roe_float: assert property (rightBus.outputEnableN |-> rightDataPinsOeN == '1)
    else $error("right data pins driven while output enable is high");

  // read data reaches the pins at the edge after the taking edge
  a_lread_data: assert property (pRd[0] |-> ##2 leftDataPinsOut == $past(g_port[0].rdWord, 2))
    else $error("left read data differs from the addressed word");
  a_rread_data: assert property (pRd[1] |-> ##2 rightDataPinsOut == $past(g_port[1].rdWord, 2))
    else $error("right read data differs from the addressed word");

  // left writes land only in selected lanes; a same-word right write on the lane is excluded
  for (genvar l = 0; l < LANES; l++) begin : g_chk
    wire logic leftLaneWr = pWr[0] && !(pWr[1] && pLane[1][l] && (pAddr[1] == pAddr[0]));
    a_lane_store: assert property (leftLaneWr && pLane[0][l] |=>
      g_lane[l].memLane[$past(pAddr[0])] == $past(leftBus.dataPinsIn[l*LANE_W +: LANE_W]))
      else $error("selected lane not stored");
    a_lane_keep: assert property (leftLaneWr && !pLane[0][l] |=>
      g_lane[l].memLane[$past(pAddr[0])] == $past(g_lane[l].memLane[pAddr[0]]))
      else $error("unselected lane was written");
  end

  // left flag checks, mirror of the right ones
  wire logic rightWrLeft = pWr[1] && rightAnyLane && (pAddr[1] == LEFT_MBOX);
  wire logic leftOwnWr   = pWr[0] && (pAddr[0] == LEFT_MBOX);
  wire logic leftRdOwn   = pRd[0] && leftAnyLane && (pAddr[0] == LEFT_MBOX);
  wire logic leftRdRight = pRd[0] && (pAddr[0] == RIGHT_MBOX);

  a_lmbox_set: assert property (rightWrLeft |=> !leftMailboxFlagN)
    else $error("left flag not set by right mailbox write");
  a_lmbox_nolane: assert property (leftMailboxFlagN && !(pWr[1] && rightAnyLane) |=> leftMailboxFlagN)
    else $error("left flag set without a lane-qualified right write");
  a_lmbox_clear: assert property (leftRdOwn && !setLeft |=> leftMailboxFlagN)
    else $error("left flag not cleared by owner read");
  a_lown_noset: assert property (leftOwnWr && leftMailboxFlagN && !setLeft |=> leftMailboxFlagN)
    else $error("own mailbox write set the left flag");
  a_rpeer_noclear: assert property (leftRdRight && !rightMailboxFlagN && !clrRight |=> !rightMailboxFlagN)
    else $error("peer read cleared the right flag");

  // flags move only on a qualified set or clear
  a_rflag_hold: assert property (!setRight && !clrRight |=> $stable(rightMailboxFlagN))
    else $error("right flag changed with no mailbox event");
  a_lflag_hold: assert property (!setLeft && !clrLeft |=> $stable(leftMailboxFlagN))
    else $error("left flag changed with no mailbox event");

  // while reset lasts every flag is high and every pin released
  a_reset_idle: assert property (disable iff (1'b0) rstAny |-> leftMailboxFlagN && rightMailboxFlagN
    && leftCounterWrapFlagN && rightCounterWrapFlagN && (leftDataPinsOeN == '1) && (rightDataPinsOeN == '1))
    else $error("reset left a flag or a pin enable active");

endmodule
`default_nettype wire

/* bench/port_master_model.sv */
// bus master model for one port: drives the port bus and resolves the data pins
// assumes the device's clk_sys; a pin nobody drives shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module port_master_model (
  input  wire logic                                clk_sys,
  input  wire logic [dpram_mailbox_pkg::DATA_W-1:0] dout,
  input  wire logic [dpram_mailbox_pkg::DATA_W-1:0] oeN,
  input  wire logic                                ownFlagN,
  input  wire logic                                peerFlagN,
  output var  dpram_mailbox_pkg::portBus_t          bus
);
  import dpram_mailbox_pkg::*;
  portBus_t          req     = '{chipSelectLowActive: 1'b1, addrStrobeN: 1'b1, counterEnableN: 1'b1, default: '0};
  logic              drv     = 1'b0;
  logic [DATA_W-1:0] lastPin = '0;
  logic [DATA_W-1:0] pin;

  // master drives the pins only for writes
  assign pin = (~oeN & dout) | (oeN & (drv ? req.dataPinsIn : ~lastPin));
  always_ff @(posedge clk_sys) lastPin <= pin;
  always_comb begin
    bus = req;
    bus.dataPinsIn = pin;
  end

  // ctl = {enable, address strobe n, counter enable n, output enable n}
  task automatic access(input logic rw, input logic [17:0] a, input logic [3:0] ln, input logic [35:0] wd,
                        input logic [3:0] ctl, output logic [35:0] rd, output logic [35:0] oe,
                        output logic [1:0] fl, output logic rel);
    @(posedge clk_sys);
    req <= '{chipSelectLowActive: ~ctl[3], chipSelectHighActive: ctl[3], readWrite: rw, byteLaneSelectsN: ln,
             outputEnableN: ctl[0], addrStrobeN: ctl[2], counterEnableN: ctl[1], addr: a, dataPinsIn: wd};
    drv <= ~rw;
    @(posedge clk_sys);
    // enable held for the taking edge only
    req <= '{chipSelectLowActive: 1'b1, outputEnableN: ctl[0], addrStrobeN: 1'b1, counterEnableN: 1'b1, default: '0};
    drv <= 1'b0;
    @(negedge clk_sys);
    fl = {ownFlagN, peerFlagN};
    @(negedge clk_sys);
    rd = pin;
    oe = oeN;
    @(negedge clk_sys);
    rel = &oeN;
  endtask
endmodule
`default_nettype wire

/* bench/dual_port_ram_mailbox_tb_top.sv */
// self-checking bench: random port traffic, mailbox flags, global reset
// assumes the two port master models in port_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module dual_port_ram_mailbox_tb_top;
  import dpram_mailbox_pkg::*;
  localparam int         AW     = ADDR_W_SMALL;
  localparam logic [3:0] CTL_ON = 4'hA;
  logic              clk_sys      = 1'b0;
  logic              sys_rst      = 1'b1;
  logic              globalResetN = 1'b0;
  portBus_t          leftBus;
  portBus_t          rightBus;
  logic [DATA_W-1:0] lOut, lOeN, rOut, rOeN, rd, oe;
  logic              lFlagN, rFlagN, lWrapN, rWrapN, rel;
  logic [1:0]        fl;
  int                errors    = 0;
  int                cmp_count = 0;
  logic [31:0]       seed      = 32'h0000_0011;
  logic [DATA_W-1:0] mem [logic [17:0]];

  always #20 clk_sys = ~clk_sys;

  dual_port_ram_mailbox #(.ADDR_W(AW)) i_dual_port_ram_mailbox (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(1'b1), .globalResetN(globalResetN),
    .leftBus(leftBus), .rightBus(rightBus), .leftDataPinsOut(lOut), .leftDataPinsOeN(lOeN),
    .rightDataPinsOut(rOut), .rightDataPinsOeN(rOeN), .leftMailboxFlagN(lFlagN),
    .rightMailboxFlagN(rFlagN), .leftCounterWrapFlagN(lWrapN), .rightCounterWrapFlagN(rWrapN));
  port_master_model i_port_master_model_l (.clk_sys(clk_sys), .dout(lOut), .oeN(lOeN),
    .ownFlagN(lFlagN), .peerFlagN(rFlagN), .bus(leftBus));
  port_master_model i_port_master_model_r (.clk_sys(clk_sys), .dout(rOut), .oeN(rOeN),
    .ownFlagN(rFlagN), .peerFlagN(lFlagN), .bus(rightBus));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [35:0] lane_mask(input logic [3:0] ln);
    for (int i = 0; i < LANES; i++) lane_mask[i*LANE_W +: LANE_W] = {LANE_W{~ln[i]}};
  endfunction

  // mailbox of owner o: right (1) is the top word, left (0) the word below
  function automatic logic [17:0] mbx(input int o);
    return (18'h1 << AW) - 18'h1 - 18'(o == 0);
  endfunction

  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic acc(input int p, input logic rw, input logic [17:0] a, input logic [3:0] ln, input logic [3:0] ctl);
    logic [35:0] wd, m;
    seed = lfsr(seed);
    wd = {seed[3:0], seed};
    if (p == 0) i_port_master_model_l.access(rw, a, ln, wd, ctl, rd, oe, fl, rel);
    else i_port_master_model_r.access(rw, a, ln, wd, ctl, rd, oe, fl, rel);
    m = ctl[3] ? lane_mask(ln) : '0;
    if (rw) begin
      check("read data", mem[a] & (ctl[0] ? '0 : m), rd & (ctl[0] ? '0 : m));
      check("read drive", ctl[0] ? '1 : ~m, oe);
    end else begin
      mem[a] = (mem[a] & ~m) | (wd & m);
    end
    check("release", 36'h0_0000_0001, {35'h0, rel});
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // mailbox steps: owner write, peer write no lanes, peer write, peer read, owner read no lanes, owner read
  localparam logic [5:0]      RW = 6'h38;
  localparam logic [5:0]      OE = 6'h20;
  localparam logic [5:0][3:0] LN = 24'h5F_0EF0;
  localparam logic [5:0][1:0] FL = 12'hD_AF;

  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    globalResetN <= 1'b1;
    for (int i = 0; i < 8; i++) acc(i % 2, 1'b0, 18'(i), 4'h0, CTL_ON);
    for (int n = 0; n < 200; n++) begin
      seed = lfsr(seed);
      acc(int'(seed[0]), seed[1], 18'(seed[4:2]), seed[8:5], {seed[9] | seed[10], 2'h1, seed[1] & seed[11]});
    end
    $display("test random access done");
    for (int o = 0; o < 2; o++) begin
      acc(o, 1'b0, mbx(o), 4'h0, CTL_ON);
      for (int s = 1; s < 6; s++) begin
        check("mailbox flags", 36'(FL[s-1]), 36'(fl));
        acc((s < 4) ? 1 - o : o, RW[s], mbx(o), LN[s], {3'h5, OE[s]});
      end
      check("mailbox flags", 36'(FL[5]), 36'(fl));
    end
    $display("test mailbox done");
    // full-range counter: top of range lowers the wrap flag, the next step reloads
    for (int p = 0; p < 2; p++) begin
      acc(p, 1'b0, mbx(0), 4'hF, 4'h0);
      for (int k = 0; k < 3; k++) begin
        acc(p, 1'b0, 18'h0_0000, 4'hF, 4'h4);
        check("wrap flag", 36'(k % 2), 36'(p == 0 ? lWrapN : rWrapN));
      end
    end
    $display("test burst counter done");
    acc(0, 1'b0, mbx(1), 4'h0, CTL_ON);
    acc(1, 1'b0, mbx(0), 4'h0, CTL_ON);
    acc(1, 1'b0, 18'h0_0005, 4'h0, 4'h8);
    @(posedge clk_sys);
    globalResetN <= 1'b0;
    @(negedge clk_sys);
    check("reset flags", 36'h0_0000_000F, {32'h0, lFlagN, rFlagN, lWrapN, rWrapN});
    check("reset release", '1, lOeN & rOeN);
    @(posedge clk_sys);
    globalResetN <= 1'b1;
    acc(1, 1'b1, 18'h0_0000, 4'h0, 4'hE);
    $display("test global reset done");
    tally_and_finish();
  end

  initial begin
    #400_000;
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
